// [core/sync_shaper_config.v]
`timescale 1ns/10ps
`default_nettype none
`include "sync_shaper_consts.vh"

// Behaviour
// - No sync action of any kind happens unless the master sync enable bit is high.
// - Sync pulses reach the clock divider only while divider sync enable and master enable are both high.
// - With master, divider and next-sync-only bits high, only the first pulse syncs the divider.
// - In next-sync-only operation the divider sync enable bit clears itself after a sync.
// - Bandwidth mode 000 selects a 22 percent band and 001 a 33 percent band.
// - Each channel's noise shaper processes data when its enable is high and is bypassed when low.
// - A 6-bit tuning word in bits 5 to 0 sets the band edges, bits 7 and 6 being reserved.
// - Each tuning step moves the band by half a percent of the sample rate.
// - Each user pattern is a 16-bit word, low byte at the lower address, high byte at the next.
module sync_shaper_config (
	input wire i_sys_clk,
	input wire i_sys_rst,
	input wire i_reg_write,
	input wire i_reg_read,
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire [1:0] i_chan_select,
	output reg [7:0] o_reg_rdata,
	output reg o_reg_rvalid,
	input wire i_sync,
	input wire [2:0] i_div_ratio,
	output wire o_sync_buffer_en,
	output reg o_div_sync_pulse,
	output reg o_div_clk_en,
	input wire [`SAMPLE_W-1:0] i_raw_data_a,
	input wire [`SAMPLE_W-1:0] i_shaped_data_a,
	input wire [`SAMPLE_W-1:0] i_raw_data_b,
	input wire [`SAMPLE_W-1:0] i_shaped_data_b,
	output wire [`SAMPLE_W-1:0] o_data_a,
	output wire [`SAMPLE_W-1:0] o_data_b,
	output wire o_noise_shaper_en_a,
	output wire o_noise_shaper_en_b,
	output wire [2:0] o_band_width_mode_a,
	output wire [2:0] o_band_width_mode_b,
	output wire [7:0] o_band_low_a,
	output wire [7:0] o_band_high_a,
	output wire [7:0] o_band_low_b,
	output wire [7:0] o_band_high_b,
	output wire o_tuning_invalid_a,
	output wire o_tuning_invalid_b,
	output wire [15:0] o_user_pattern_two,
	output wire [15:0] o_user_pattern_three,
	output wire [15:0] o_user_pattern_four
);

////////////////////////////////////////////////////////////////////////////////
// global registers

reg [7:0] pattern_reg [0:5];
reg [7:0] sync_control_reg;
reg [7:0] sync_control_next;
reg sync_prev_reg;
reg [2:0] div_count_reg;
reg [2:0] div_count_next;
reg [5:0] pattern_write;
reg [1:0] sync_mode;
reg sync_gate;
reg sync_self_clear;

wire sync_edge;
wire master_en;
wire divider_en;
wire next_only;
wire sync_accept;
wire sync_write;
wire [7:0] chan_control [0:1];
wire [7:0] chan_tuning [0:1];
wire [`SAMPLE_W-1:0] chan_raw [0:1];
wire [`SAMPLE_W-1:0] chan_shaped [0:1];
wire [`SAMPLE_W-1:0] chan_data [0:1];
wire [7:0] chan_band_low [0:1];
wire [7:0] chan_band_high [0:1];
wire [1:0] chan_invalid;
wire [1:0] chan_write;
wire div_wrap;
reg [7:0] read_value;
reg [7:0] global_value;
reg [7:0] local_value;
reg global_hit;
reg read_chan;

// sync operating modes decoded from the control bits
localparam [1:0] SYNC_MODE_OFF = 2'h0;
localparam [1:0] SYNC_MODE_HOLD = 2'h1;
localparam [1:0] SYNC_MODE_CONTINUOUS = 2'h2;
localparam [1:0] SYNC_MODE_ONE_SHOT = 2'h3;

////////////////////////////////////////////////////////////////////////////////
// user test pattern bytes, low byte at the lower address

// one write enable per pattern byte
always @* begin
	pattern_write = 6'h00;
	if (i_reg_write) begin
		case (i_reg_addr)
			`ADDR_USER_PATTERN_TWO_LOW: pattern_write = 6'h01;
			`ADDR_USER_PATTERN_TWO_HIGH: pattern_write = 6'h02;
			`ADDR_USER_PATTERN_THREE_LOW: pattern_write = 6'h04;
			`ADDR_USER_PATTERN_THREE_HIGH: pattern_write = 6'h08;
			`ADDR_USER_PATTERN_FOUR_LOW: pattern_write = 6'h10;
			`ADDR_USER_PATTERN_FOUR_HIGH: pattern_write = 6'h20;
			default: pattern_write = 6'h00;
		endcase
	end
end

genvar p;
generate
	for (p = 0; p < 6; p = p + 1) begin : g_pattern
		always @(posedge i_sys_clk or posedge i_sys_rst) begin
			if (i_sys_rst)
				pattern_reg[p] <= `RST_USER_PATTERN;
			else if (pattern_write[p])
				pattern_reg[p] <= i_reg_wdata;
		end
	end
endgenerate

assign o_user_pattern_two = {pattern_reg[1], pattern_reg[0]};
assign o_user_pattern_three = {pattern_reg[3], pattern_reg[2]};
assign o_user_pattern_four = {pattern_reg[5], pattern_reg[4]};

////////////////////////////////////////////////////////////////////////////////
// sync control

assign master_en = sync_control_reg[`SYNC_MASTER_BIT];
assign divider_en = sync_control_reg[`SYNC_DIVIDER_BIT];
assign next_only = sync_control_reg[`SYNC_NEXT_ONLY_BIT];
// sync buffer powered only with the master enable
assign o_sync_buffer_en = master_en;
assign sync_edge = i_sync & ~sync_prev_reg;
assign sync_accept = sync_gate & sync_edge;
assign sync_write = i_reg_write && (i_reg_addr == `ADDR_DIVIDER_SYNC_CONTROL);

always @* begin
	if (!master_en)
		sync_mode = SYNC_MODE_OFF;
	else if (!divider_en)
		sync_mode = SYNC_MODE_HOLD;
	else if (next_only)
		sync_mode = SYNC_MODE_ONE_SHOT;
	else
		sync_mode = SYNC_MODE_CONTINUOUS;
end

// pulses pass to the divider only in the two gated modes
always @* begin
	case (sync_mode)
		SYNC_MODE_CONTINUOUS: begin
			sync_gate = 1'b1;
			sync_self_clear = 1'b0;
		end
		SYNC_MODE_ONE_SHOT: begin
			sync_gate = 1'b1;
			sync_self_clear = 1'b1;
		end
		default: begin
			sync_gate = 1'b0;
			sync_self_clear = 1'b0;
		end
	endcase
end

always @* begin
	sync_control_next = sync_control_reg;
	// one-shot: drop the divider enable after the first accepted pulse
	if (sync_accept && sync_self_clear)
		sync_control_next[`SYNC_DIVIDER_BIT] = 1'b0;
	// a host write in the same cycle wins over the self clear
	if (sync_write)
		sync_control_next = i_reg_wdata & `SYNC_CONTROL_MASK;
end

always @(posedge i_sys_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		sync_control_reg <= `RST_DIVIDER_SYNC_CONTROL;
		sync_prev_reg <= 1'b0;
		o_div_sync_pulse <= 1'b0;
	end else begin
		sync_control_reg <= sync_control_next;
		// edge detector idles with the buffer off
		sync_prev_reg <= i_sync & master_en;
		o_div_sync_pulse <= sync_accept;
	end
end

////////////////////////////////////////////////////////////////////////////////
// integer input clock divider, ratio 1 to 8

// wrap after ratio plus one input clocks
assign div_wrap = (div_count_reg >= i_div_ratio);

always @* begin
	if (sync_accept)
		div_count_next = 3'h0;
	else if (div_wrap)
		div_count_next = 3'h0;
	else
		div_count_next = div_count_reg + 3'h1;
end

always @(posedge i_sys_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		div_count_reg <= 3'h0;
		o_div_clk_en <= 1'b0;
	end else begin
		div_count_reg <= div_count_next;
		o_div_clk_en <= (div_count_next == 3'h0);
	end
end

////////////////////////////////////////////////////////////////////////////////
// per-channel noise shaper settings

assign chan_raw[0] = i_raw_data_a;
assign chan_raw[1] = i_raw_data_b;
assign chan_shaped[0] = i_shaped_data_a;
assign chan_shaped[1] = i_shaped_data_b;

genvar c;
generate
	for (c = 0; c < 2; c = c + 1) begin : g_chan
		assign chan_write[c] = i_reg_write & i_chan_select[c];
		channel_shaper_regs u_regs (
			.i_sys_clk(i_sys_clk),
			.i_sys_rst(i_sys_rst),
			.i_write(chan_write[c]),
			.i_addr(i_reg_addr),
			.i_wdata(i_reg_wdata),
			.i_raw_data(chan_raw[c]),
			.i_shaped_data(chan_shaped[c]),
			.o_control(chan_control[c]),
			.o_tuning(chan_tuning[c]),
			.o_data(chan_data[c]),
			.o_band_low(chan_band_low[c]),
			.o_band_high(chan_band_high[c]),
			.o_tuning_invalid(chan_invalid[c])
		);
	end
endgenerate

assign o_data_a = chan_data[0];
assign o_data_b = chan_data[1];
assign o_noise_shaper_en_a = chan_control[0][`SHAPER_ENABLE_BIT];
assign o_noise_shaper_en_b = chan_control[1][`SHAPER_ENABLE_BIT];
assign o_band_width_mode_a = chan_control[0][`SHAPER_MODE_MSB:`SHAPER_MODE_LSB];
assign o_band_width_mode_b = chan_control[1][`SHAPER_MODE_MSB:`SHAPER_MODE_LSB];
assign o_band_low_a = chan_band_low[0];
assign o_band_high_a = chan_band_high[0];
assign o_band_low_b = chan_band_low[1];
assign o_band_high_b = chan_band_high[1];
assign o_tuning_invalid_a = chan_invalid[0];
assign o_tuning_invalid_b = chan_invalid[1];

////////////////////////////////////////////////////////////////////////////////
// read back; global registers answer whatever the channel index

always @* begin
	global_hit = 1'b1;
	case (i_reg_addr)
		`ADDR_USER_PATTERN_TWO_LOW: global_value = pattern_reg[0];
		`ADDR_USER_PATTERN_TWO_HIGH: global_value = pattern_reg[1];
		`ADDR_USER_PATTERN_THREE_LOW: global_value = pattern_reg[2];
		`ADDR_USER_PATTERN_THREE_HIGH: global_value = pattern_reg[3];
		`ADDR_USER_PATTERN_FOUR_LOW: global_value = pattern_reg[4];
		`ADDR_USER_PATTERN_FOUR_HIGH: global_value = pattern_reg[5];
		`ADDR_DIVIDER_SYNC_CONTROL: global_value = sync_control_reg;
		default: begin
			global_hit = 1'b0;
			global_value = 8'h00;
		end
	endcase
end

// local registers from the lowest selected channel
always @* begin
	read_chan = ~i_chan_select[0] & i_chan_select[1];
	case (i_reg_addr)
		`ADDR_NOISE_SHAPER_CONTROL: local_value = chan_control[read_chan];
		`ADDR_NOISE_SHAPER_BAND_TUNING: local_value = chan_tuning[read_chan];
		default: local_value = 8'h00;
	endcase
end

// unmapped addresses read as zero
always @* begin
	if (global_hit)
		read_value = global_value;
	else
		read_value = local_value;
end

always @(posedge i_sys_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		o_reg_rdata <= 8'h00;
		o_reg_rvalid <= 1'b0;
	end else begin
		o_reg_rvalid <= i_reg_read;
		if (i_reg_read)
			o_reg_rdata <= read_value;
	end
end

endmodule
`default_nettype wire

// [common/sync_shaper_consts.vh]
`ifndef SYNC_SHAPER_CONSTS_VH
`define SYNC_SHAPER_CONSTS_VH

// register offsets
`define ADDR_USER_PATTERN_TWO_LOW 8'h1B
`define ADDR_USER_PATTERN_TWO_HIGH 8'h1C
`define ADDR_USER_PATTERN_THREE_LOW 8'h1D
`define ADDR_USER_PATTERN_THREE_HIGH 8'h1E
`define ADDR_USER_PATTERN_FOUR_LOW 8'h1F
`define ADDR_USER_PATTERN_FOUR_HIGH 8'h20
`define ADDR_DIVIDER_SYNC_CONTROL 8'h3A
`define ADDR_NOISE_SHAPER_CONTROL 8'h3C
`define ADDR_NOISE_SHAPER_BAND_TUNING 8'h3E

// reset values
`define RST_USER_PATTERN 8'h00
`define RST_DIVIDER_SYNC_CONTROL 8'h00
`define RST_NOISE_SHAPER_CONTROL 8'h00
`define RST_NOISE_SHAPER_BAND_TUNING 8'h1C

// divider_sync_control fields
`define SYNC_MASTER_BIT 0
`define SYNC_DIVIDER_BIT 1
`define SYNC_NEXT_ONLY_BIT 2
`define SYNC_CONTROL_MASK 8'h07

// noise_shaper_control fields
`define SHAPER_ENABLE_BIT 0
`define SHAPER_MODE_MSB 3
`define SHAPER_MODE_LSB 1
`define SHAPER_CONTROL_MASK 8'h0F
`define MODE_BW_22 3'h0
`define MODE_BW_33 3'h1

// noise_shaper_band_tuning fields
`define TUNING_MSB 5
`define TUNING_MASK 8'h3F

// band geometry in half-percent steps of the sample rate
`define BAND_SPAN_22 8'h2C
`define BAND_SPAN_33 8'h42
`define TUNING_COUNT_22 6'h39
`define TUNING_COUNT_33 6'h22

// sample width
`define SAMPLE_W 11

`endif

// [core/channel_shaper_regs.v]
`timescale 1ns/10ps
`default_nettype none
`include "sync_shaper_consts.vh"

module channel_shaper_regs (
	input wire i_sys_clk,
	input wire i_sys_rst,
	input wire i_write,
	input wire [7:0] i_addr,
	input wire [7:0] i_wdata,
	input wire [`SAMPLE_W-1:0] i_raw_data,
	input wire [`SAMPLE_W-1:0] i_shaped_data,
	output wire [7:0] o_control,
	output wire [7:0] o_tuning,
	output reg [`SAMPLE_W-1:0] o_data,
	output reg [7:0] o_band_low,
	output reg [7:0] o_band_high,
	output reg o_tuning_invalid
);

reg [7:0] control_reg;
reg [7:0] tuning_reg;
wire [2:0] band_width_mode;
wire [7:0] band_span;
wire [5:0] tuning_count;

////////////////////////////////////////////////////////////////////////////////
always @(posedge i_sys_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		control_reg <= `RST_NOISE_SHAPER_CONTROL;
		tuning_reg <= `RST_NOISE_SHAPER_BAND_TUNING;
	end else if (i_write) begin
		if (i_addr == `ADDR_NOISE_SHAPER_CONTROL)
			control_reg <= i_wdata & `SHAPER_CONTROL_MASK;
		if (i_addr == `ADDR_NOISE_SHAPER_BAND_TUNING)
			tuning_reg <= i_wdata & `TUNING_MASK;
	end
end

assign o_control = control_reg;
assign o_tuning = tuning_reg;
assign band_width_mode = control_reg[`SHAPER_MODE_MSB:`SHAPER_MODE_LSB];
// 000 selects the 22 percent band, 001 the 33 percent band
assign band_span = (band_width_mode == `MODE_BW_33) ? `BAND_SPAN_33 : `BAND_SPAN_22;
assign tuning_count = (band_width_mode == `MODE_BW_33) ? `TUNING_COUNT_33 : `TUNING_COUNT_22;

////////////////////////////////////////////////////////////////////////////////
// band edges in half-percent units, one step per tuning increment
always @(posedge i_sys_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		o_data <= {`SAMPLE_W{1'b0}};
		o_band_low <= 8'h00;
		o_band_high <= 8'h00;
		o_tuning_invalid <= 1'b0;
	end else begin
		o_data <= control_reg[`SHAPER_ENABLE_BIT] ? i_shaped_data : i_raw_data;
		o_band_low <= {2'h0, tuning_reg[`TUNING_MSB:0]};
		o_band_high <= {2'h0, tuning_reg[`TUNING_MSB:0]} + band_span;
		o_tuning_invalid <= (tuning_reg[`TUNING_MSB:0] >= tuning_count);
	end
end

endmodule
`default_nettype wire

// [bench/sync_shaper_config_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sync_shaper_consts.vh"
module sync_shaper_checker (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_reg_read,
	input wire logic o_reg_rvalid,
	input wire logic i_sync,
	input wire logic o_sync_buffer_en,
	input wire logic o_div_sync_pulse,
	input wire logic o_div_clk_en,
	input wire logic [`SAMPLE_W-1:0] i_raw_data_a,
	input wire logic [`SAMPLE_W-1:0] i_shaped_data_a,
	input wire logic [`SAMPLE_W-1:0] o_data_a,
	input wire logic o_noise_shaper_en_a,
	input wire logic [2:0] o_band_width_mode_a,
	input wire logic [7:0] o_band_low_a,
	input wire logic [7:0] o_band_high_a,
	input wire logic o_tuning_invalid_a
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	// outputs settled from a full cycle out of reset
	sequence s_settled;
		!$past(i_sys_rst);
	endsequence
	sequence s_rise;
		!$past(i_sync, 2) && $past(i_sync);
	endsequence
	a_sync_needs_master: assert property (!o_sync_buffer_en |=> !o_div_sync_pulse)
		else $error("sync pulse without master enable");
	a_sync_from_edge: assert property (o_div_sync_pulse |-> s_rise)
		else $error("sync pulse without input edge");
	a_pulse_one_cycle: assert property (o_div_sync_pulse |=> !o_div_sync_pulse)
		else $error("sync pulse too long");
	a_clk_en_aligned: assert property (o_div_sync_pulse |-> o_div_clk_en)
		else $error("divider phase not reset");
	a_data_select: assert property (s_settled |-> o_data_a == ($past(o_noise_shaper_en_a) ?
		$past(i_shaped_data_a) : $past(i_raw_data_a))) else $error("data path select wrong");
	a_band_span: assert property (s_settled |-> o_band_high_a == o_band_low_a +
		($past(o_band_width_mode_a) == 3'h1 ? 8'h42 : 8'h2C)) else $error("band span wrong");
	a_tuning_flag: assert property (s_settled |-> o_tuning_invalid_a == ($past(o_band_width_mode_a) == 3'h1 ?
		o_band_low_a >= 8'h22 : o_band_low_a >= 8'h39)) else $error("tuning flag wrong");
	a_read_answer: assert property (s_settled |-> o_reg_rvalid == $past(i_reg_read))
		else $error("read answer timing wrong");
	c_sync: cover property (s_rise ##0 o_div_sync_pulse);
endmodule
bind sync_shaper_config sync_shaper_checker chk_i (.i_sys_clk, .i_sys_rst, .i_reg_read, .o_reg_rvalid, .i_sync,
	.o_sync_buffer_en, .o_div_sync_pulse, .o_div_clk_en, .i_raw_data_a, .i_shaped_data_a, .o_data_a,
	.o_noise_shaper_en_a, .o_band_width_mode_a, .o_band_low_a, .o_band_high_a, .o_tuning_invalid_a);
`default_nettype wire

// [bench/host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_rdata,
	input wire logic i_rvalid,
	output logic o_write,
	output logic o_read,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic [1:0] o_chan
);
	initial begin
		o_write = 1'b0;
		o_read = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_chan = 2'h3;
	end
	// one strobe per call, bus scrambled once released
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_sys_clk);
		o_write = 1'b1;
		o_addr = a;
		o_wdata = d;
		@(negedge i_sys_clk);
		o_write = 1'b0;
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge i_sys_clk);
		o_read = 1'b1;
		o_addr = a;
		@(negedge i_sys_clk);
		d = i_rdata;
		v = i_rvalid;
		o_read = 1'b0;
		o_addr = ~o_addr;
	endtask
endmodule
`default_nettype wire

// [bench/sync_shaper_config_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sync_shaper_consts.vh"
module sync_shaper_config_tb_top;
	logic i_sys_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_sync = 1'b0;
	logic [2:0] i_div_ratio = 3'h3;
	logic [7:0] rs = 8'h59;
	logic [7:0] ds = 8'h59;
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	int mem [0:255];
	int ctl [2];
	int tun [2];
	logic [7:0] adr [11] = '{8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h3A, 8'h3C, 8'h3E, 8'h3B, 8'h21};
	logic [7:0] tw [4] = '{8'h21, 8'h22, 8'h38, 8'h39};
	logic [7:0] cvs [6] = '{8'h00, 8'h02, 8'h01, 8'h03, 8'h07, 8'h05};
	wire i_reg_write, i_reg_read, o_reg_rvalid, o_sync_buffer_en, o_div_sync_pulse, o_div_clk_en;
	wire o_noise_shaper_en_a, o_noise_shaper_en_b, o_tuning_invalid_a, o_tuning_invalid_b;
	wire [1:0] i_chan_select;
	wire [2:0] o_band_width_mode_a, o_band_width_mode_b;
	wire [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_band_low_a, o_band_high_a, o_band_low_b, o_band_high_b;
	wire [15:0] o_user_pattern_two, o_user_pattern_three, o_user_pattern_four;
	wire [`SAMPLE_W-1:0] o_data_a, o_data_b;
	wire [`SAMPLE_W-1:0] i_raw_data_a = {ds, 3'h1};
	wire [`SAMPLE_W-1:0] i_shaped_data_a = {3'h2, ds};
	wire [`SAMPLE_W-1:0] i_raw_data_b = {ds[3:0], ds[7:1]};
	wire [`SAMPLE_W-1:0] i_shaped_data_b = ~{ds, ds[2:0]};
	sync_shaper_config dut (.i_sys_clk, .i_sys_rst, .i_reg_write, .i_reg_read, .i_reg_addr, .i_reg_wdata,
		.i_chan_select, .o_reg_rdata, .o_reg_rvalid, .i_sync, .i_div_ratio, .o_sync_buffer_en, .o_div_sync_pulse,
		.o_div_clk_en, .i_raw_data_a, .i_shaped_data_a, .i_raw_data_b, .i_shaped_data_b, .o_data_a, .o_data_b,
		.o_noise_shaper_en_a, .o_noise_shaper_en_b, .o_band_width_mode_a, .o_band_width_mode_b, .o_band_low_a,
		.o_band_high_a, .o_band_low_b, .o_band_high_b, .o_tuning_invalid_a, .o_tuning_invalid_b,
		.o_user_pattern_two, .o_user_pattern_three, .o_user_pattern_four);
	host_model h (.i_sys_clk, .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid), .o_write(i_reg_write),
		.o_read(i_reg_read), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata), .o_chan(i_chan_select));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	always #4 i_sys_clk = ~i_sys_clk;
	always @(negedge i_sys_clk) ds <= lfsr(ds);
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			conclude;
		end
	end
	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error %0t got %h expected %h", $time, g, e);
		end
	endtask
	task do_wr(input logic [7:0] ad, input logic [7:0] d);
		h.wr(ad, d);
		if (ad >= 8'h1B && ad <= 8'h20) mem[ad] = d;
		if (ad == 8'h3A) mem[ad] = d & 8'h07;
		for (int c = 0; c < 2; c++) begin
			if (i_chan_select[c] && ad == 8'h3C) ctl[c] = d & 8'h0F;
			if (i_chan_select[c] && ad == 8'h3E) tun[c] = d & 8'h3F;
		end
	endtask
	task do_rd(input logic [7:0] ad);
		logic [7:0] d;
		logic v;
		int lc;
		h.rd(ad, d, v);
		lc = !i_chan_select[0] && i_chan_select[1];
		chk(v, 1'b1);
		chk(d, ad == 8'h3C ? ctl[lc] : ad == 8'h3E ? tun[lc] : mem[ad]);
	endtask
	task automatic chk_ch(input int c, input logic [7:0] lo, input logic [7:0] hi, input logic [2:0] md,
		input logic en, input logic inv);
		int m = (ctl[c] >> 1) & 7;
		chk(en, ctl[c] & 1);
		chk(md, m);
		chk(lo, tun[c]);
		chk(hi, tun[c] + (m == 1 ? 66 : 44));
		chk(inv, tun[c] >= (m == 1 ? 34 : 57));
	endtask
	task automatic sync_try(input logic [7:0] cv);
		int n = 0;
		do_wr(8'h3A, cv);
		repeat (2) begin
			@(negedge i_sys_clk) i_sync = 1'b1;
			repeat (3) @(negedge i_sys_clk) n += o_div_sync_pulse;
			i_sync = 1'b0;
			repeat (3) @(negedge i_sys_clk) n += o_div_sync_pulse;
		end
		if (cv[2:0] == 3'h7) mem[8'h3A] = 5;
		chk(n, cv[1:0] == 2'h3 ? (cv[2] ? 1 : 2) : 0);
		chk(o_sync_buffer_en, cv[0]);
		do_rd(8'h3A);
	endtask
	initial begin
		foreach (mem[i]) mem[i] = 0;
		ctl = '{0, 0};
		tun = '{28, 28};
		repeat (5) @(posedge i_sys_clk);
		@(negedge i_sys_clk) i_sys_rst = 1'b0;
		foreach (adr[i]) do_rd(adr[i]);
		foreach (adr[i]) begin
			rs = lfsr(rs);
			do_wr(adr[i], rs);
			do_rd(adr[i]);
		end
		chk(o_user_pattern_two, {mem[8'h1C][7:0], mem[8'h1B][7:0]});
		chk(o_user_pattern_three, {mem[8'h1E][7:0], mem[8'h1D][7:0]});
		chk(o_user_pattern_four, {mem[8'h20][7:0], mem[8'h1F][7:0]});
		for (int m = 0; m < 2; m++) begin
			foreach (tw[j]) begin
				h.o_chan = 2'h1;
				do_wr(8'h3C, 8'hF1 | (m << 1));
				h.o_chan = 2'h2;
				do_wr(8'h3C, m << 1);
				h.o_chan = 2'h0;
				do_wr(8'h3C, 8'h0E);
				h.o_chan = 2'h3;
				do_wr(8'h3E, tw[j] | 8'hC0);
				repeat (2) @(negedge i_sys_clk);
				chk_ch(0, o_band_low_a, o_band_high_a, o_band_width_mode_a, o_noise_shaper_en_a, o_tuning_invalid_a);
				chk_ch(1, o_band_low_b, o_band_high_b, o_band_width_mode_b, o_noise_shaper_en_b, o_tuning_invalid_b);
				chk(o_data_a, ctl[0] & 1 ? i_shaped_data_a : i_raw_data_a);
				chk(o_data_b, ctl[1] & 1 ? i_shaped_data_b : i_raw_data_b);
				do_rd(8'h3C);
				h.o_chan = 2'h2;
				do_rd(8'h3C);
			end
		end
		foreach (cvs[i]) sync_try(cvs[i]);
		do_wr(8'h3A, 8'h00);
		for (int r = 0; r < 8; r++) begin
			int k;
			k = 0;
			@(negedge i_sys_clk) i_div_ratio = r[2:0];
			repeat (9) @(negedge i_sys_clk);
			repeat (8 * (r + 1)) @(negedge i_sys_clk) k += o_div_clk_en;
			chk(k, 8);
		end
		conclude;
	end
endmodule
`default_nettype wire
